// ### hdl/pin_status_pkg.sv
package pin_status_pkg;

  // ---------------------------------------------------------------
  // bus register map
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CFG       = 12'h000;
  localparam logic [11:0] OFS_GPIO_DIR  = 12'h004;
  localparam logic [11:0] OFS_GPIO_VAL  = 12'h008;
  localparam logic [11:0] OFS_MAXPWR    = 12'h00c;
  localparam logic [11:0] OFS_CTRL      = 12'h010;
  localparam logic [11:0] OFS_STATUS    = 12'h014;
  localparam logic [11:0] OFS_SENSE     = 12'h018;
  localparam logic [11:0] OFS_EP1       = 12'h01c;

  // ---------------------------------------------------------------
  // configuration byte 0x08 field positions
  // ---------------------------------------------------------------
  localparam int CFG_MEDIA_EN_BIT  = 0;
  localparam int CFG_MEDIA_POL_BIT = 1;
  localparam int CFG_FLOAT_BIT     = 4;
  localparam int CFG_SEARCH_BIT    = 6;

  // control register field positions
  localparam int CTRL_APPLY_BIT    = 0;  // write 1: load gpio defaults
  localparam int CTRL_SUSPEND_BIT  = 1;
  localparam int CTRL_ATA_ACT_BIT  = 2;
  localparam int CTRL_USB_RST_BIT  = 3;  // write 1: usb reset seen
  localparam int CTRL_QUERY_BIT    = 4;  // write 1: host status query
  localparam int CTRL_AWAKE_INDICATOR_N_BIT   = 5;
  localparam int CTRL_HS_BIT       = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_RST      = 8'h00;
  localparam logic [7:0] GPIO_DIR_RST = 8'h00;
  localparam logic [7:0] GPIO_VAL_RST = 8'h00;
  localparam logic [7:0] MAXPWR_RST   = 8'hfa;

  // ---------------------------------------------------------------
  // descriptor and sense values
  // ---------------------------------------------------------------
  localparam logic [7:0] MAXPWR_BUS    = 8'hfa;
  localparam logic [7:0] MAXPWR_SELF   = 8'h01;
  localparam logic [7:0] ASC_NO_MEDIA  = 8'h3a;
  localparam logic [7:0] ASC_CHANGED   = 8'h28;
  localparam logic [7:0] ASC_NONE      = 8'h00;
  localparam logic [7:0] ASCQ_ZERO     = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 25_000_000;
  localparam int VBUS_POLL_MS    = 20;
  localparam int VBUS_POLL_CYC   = CLK_HZ / 1000 * VBUS_POLL_MS;

  // sense answer carried together
  typedef struct packed {
    logic [7:0] asc;
    logic [7:0] ascq;
  } sense_t;

endpackage

// ### hdl/pin_status.sv
`timescale 1ns/100ps
`default_nettype none
module pin_status
  import pin_status_pkg::*;
#(
  parameter int POLL_CYC   = VBUS_POLL_CYC,
  parameter int GPIO_W     = 6,
  parameter bit HAS_PWRSEL = 1'b1
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              media_present_input,
  input  wire logic              vbus_present_input,
  input  wire logic              power_source_select,
  input  wire logic              system_service_request,
  input  wire logic [GPIO_W-1:0] gpio_in,
  output logic      [GPIO_W-1:0] gpio_out,
  output logic      [GPIO_W-1:0] gpio_oe,
  output logic                   awake_indicator_n_out,
  output logic                   awake_indicator_n_oe,
  output logic                   ata_pullup_control_out,
  output logic                   ata_pullup_control_oe,
  output logic                   ata_pins_oe,
  output logic                   ata_pins_active,
  output logic                   dplus_pullup,
  output logic                   high_current_grant_n,
  output logic                   media_present,
  output logic                   ep1_valid,
  output logic      [15:0]       ep1_data
);

  // ---------------------------------------------------------------
  // configuration and control storage
  // ---------------------------------------------------------------
  logic [7:0]        cfg_q;
  logic [7:0]        gdir_dflt_q;
  logic [7:0]        gval_dflt_q;
  logic [7:0]        maxpwr_cfg_q;
  logic              suspend_q;
  logic              ata_act_q;
  logic              awake_indicator_n_q;
  logic              hs_q;
  logic              wr_en;
  logic              rd_en;
  logic              apply_pulse;
  logic              usb_rst_pulse;
  logic              query_pulse;

  // strobe bit of a control word written by the completing access
  function automatic logic ctrl_strobe(input logic        we,
                                       input logic [11:0] addr,
                                       input logic [31:0] data,
                                       input int          bit_pos);
    return we & (addr == OFS_CTRL) & data[bit_pos];
  endfunction

  // the access completes at the edge where pready is already high; writes and
  // read side effects land there only, so a request held for the wait acts once
  logic access_done;

  assign access_done   = psel & penable & pready;
  assign wr_en         = access_done & pwrite;
  assign rd_en         = access_done & ~pwrite;
  assign apply_pulse   = ctrl_strobe(wr_en, paddr, pwdata, CTRL_APPLY_BIT);
  assign usb_rst_pulse = ctrl_strobe(wr_en, paddr, pwdata, CTRL_USB_RST_BIT);
  assign query_pulse   = ctrl_strobe(wr_en, paddr, pwdata, CTRL_QUERY_BIT);

  // configuration byte images
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q        <= CFG_RST;
      gdir_dflt_q  <= GPIO_DIR_RST;
      gval_dflt_q  <= GPIO_VAL_RST;
      maxpwr_cfg_q <= MAXPWR_RST;
    end else if (wr_en) begin
      case (paddr)
        OFS_CFG:      cfg_q        <= pwdata[7:0];
        OFS_GPIO_DIR: gdir_dflt_q  <= pwdata[7:0];
        OFS_GPIO_VAL: gval_dflt_q  <= pwdata[7:0];
        OFS_MAXPWR:   maxpwr_cfg_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // control levels; the strobe bits of the same word are not stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      suspend_q <= 1'b0;
      ata_act_q <= 1'b0;
      awake_indicator_n_q  <= 1'b0;
      hs_q      <= 1'b0;
    end else if (wr_en && paddr == OFS_CTRL) begin
      suspend_q <= pwdata[CTRL_SUSPEND_BIT];
      ata_act_q <= pwdata[CTRL_ATA_ACT_BIT];
      awake_indicator_n_q  <= pwdata[CTRL_AWAKE_INDICATOR_N_BIT];
      hs_q      <= pwdata[CTRL_HS_BIT];
    end
  end

  // ---------------------------------------------------------------
  // gpio defaults
  // ---------------------------------------------------------------
  // defaults take effect on an apply strobe, not on every byte write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gpio_oe  <= '0;
      gpio_out <= '0;
    end else if (apply_pulse) begin
      gpio_oe  <= gdir_dflt_q[GPIO_W-1:0];
      gpio_out <= gval_dflt_q[GPIO_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // vbus polling
  // ---------------------------------------------------------------
  logic [31:0] poll_cnt_q;
  logic        first_q;
  logic        vbus_q;
  logic        poll_tick;

  // one-cycle enable: first cycle out of reset, then once every poll period
  assign poll_tick = first_q | (poll_cnt_q == 32'(POLL_CYC - 1));

  // poll timer, first tick right after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      poll_cnt_q <= '0;
      first_q    <= 1'b1;
    end else begin
      first_q    <= 1'b0;
      poll_cnt_q <= poll_tick ? '0 : poll_cnt_q + 32'd1;
    end
  end

  // vbus sample held between ticks; a short dip between polls is not seen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vbus_q <= 1'b0;
    end else if (poll_tick) begin
      vbus_q <= vbus_present_input;
    end
  end

  // ---------------------------------------------------------------
  // media detection and sense
  // ---------------------------------------------------------------
  logic   media_lvl;
  logic   absent_seen_q;
  sense_t sense_q;

  // polarity select, then enable
  assign media_lvl = cfg_q[CFG_MEDIA_EN_BIT] &
                     (media_present_input ~^ cfg_q[CFG_MEDIA_POL_BIT]);

  // media enabled but not at its active level
  function automatic logic media_gone(input logic [7:0] cfg, input logic lvl);
    return cfg[CFG_MEDIA_EN_BIT] & ~lvl;
  endfunction

  // the removable device is the master, reported as a single unit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      media_present <= 1'b0;
    end else begin
      media_present <= media_lvl;
    end
  end

  // absence memory; an absence in the query cycle wins over the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      absent_seen_q <= 1'b0;
    end else if (media_gone(cfg_q, media_lvl)) begin
      absent_seen_q <= 1'b1;
    end else if (query_pulse) begin
      absent_seen_q <= 1'b0;
    end
  end

  // sense answer chosen at the query, held until the next one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_q <= '{asc: ASC_NONE, ascq: ASCQ_ZERO};
    end else if (query_pulse) begin
      if (media_gone(cfg_q, media_lvl)) begin
        sense_q <= '{asc: ASC_NO_MEDIA, ascq: ASCQ_ZERO};
      end else if (absent_seen_q) begin
        sense_q <= '{asc: ASC_CHANGED, ascq: ASCQ_ZERO};
      end else begin
        sense_q <= '{asc: ASC_NONE, ascq: ASCQ_ZERO};
      end
    end
  end

  // ---------------------------------------------------------------
  // power descriptor values, latched only at reset events
  // ---------------------------------------------------------------
  logic [7:0] maxpwr_q;
  logic       selfpwr_q;
  logic       pwr_load_q;

  // load one cycle after reset release or a usb reset strobe; the select pin
  // is ignored in between, as a host reads descriptors only after a reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      maxpwr_q   <= MAXPWR_BUS;
      selfpwr_q  <= 1'b0;
      pwr_load_q <= 1'b1;
    end else begin
      pwr_load_q <= usb_rst_pulse;
      if (pwr_load_q) begin
        if (HAS_PWRSEL) begin
          maxpwr_q  <= power_source_select ? MAXPWR_BUS : MAXPWR_SELF;
          selfpwr_q <= ~power_source_select;
        end else begin
          maxpwr_q  <= maxpwr_cfg_q;
          selfpwr_q <= (maxpwr_cfg_q <= MAXPWR_SELF);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  logic ata_float;

  // the ata bus is live only while it is asked for and vbus is seen
  function automatic logic ata_live(input logic act, input logic vbus);
    return act & vbus;
  endfunction

  // float only when enabled and vbus is not seen; otherwise the pins stay driven, parked inactive without vbus
  assign ata_float = cfg_q[CFG_FLOAT_BIT] & ~vbus_q;

  // awake indicator: low while awake, released in suspend
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awake_indicator_n_out <= 1'b0;
      awake_indicator_n_oe  <= 1'b0;
    end else begin
      awake_indicator_n_out <= 1'b0;
      awake_indicator_n_oe  <= ~suspend_q;
    end
  end

  // ata pins and their pull-up control follow the sampled vbus, not the pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ata_pins_oe            <= 1'b0;
      ata_pins_active        <= 1'b0;
      ata_pullup_control_out <= 1'b0;
      ata_pullup_control_oe  <= 1'b0;
    end else begin
      ata_pins_oe            <= ~ata_float;
      ata_pins_active        <= ata_live(ata_act_q, vbus_q);
      ata_pullup_control_out <= ata_live(ata_act_q, vbus_q);
      ata_pullup_control_oe  <= ~ata_float;
    end
  end

  // d+ pull-up released on any zero vbus sample
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dplus_pullup <= 1'b0;
    end else begin
      dplus_pullup <= vbus_q;
    end
  end

  // high-current grant, active low; dropped in suspend or low power
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      high_current_grant_n <= 1'b1;
    end else begin
      high_current_grant_n <= awake_indicator_n_q | suspend_q;
    end
  end

  // ---------------------------------------------------------------
  // interrupt endpoint data
  // ---------------------------------------------------------------
  logic [7:0] gpio_rep;

  always_comb begin
    gpio_rep = '0;
    gpio_rep[GPIO_W-1:0] = gpio_in & ~gpio_oe; // outputs read as zero
  end

  // latch on a service request, cleared by reading the word
  // a request in the reading cycle wins, so no event is lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ep1_valid <= 1'b0;
      ep1_data  <= '0;
    end else if (system_service_request) begin
      ep1_valid <= 1'b1;
      ep1_data  <= {6'h00, hs_q, ~selfpwr_q, 2'b00, gpio_rep[5:0]};
    end else if (rd_en && paddr == OFS_EP1) begin
      ep1_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // apb read path
  // ---------------------------------------------------------------
  logic [31:0] rdata_d;
  logic        err_d;

  always_comb begin
    rdata_d = '0;
    err_d   = 1'b0;
    case (paddr)
      OFS_CFG:      rdata_d[7:0] = cfg_q;
      OFS_GPIO_DIR: rdata_d[7:0] = gdir_dflt_q;
      OFS_GPIO_VAL: rdata_d[7:0] = gval_dflt_q;
      OFS_MAXPWR:   rdata_d[7:0] = maxpwr_cfg_q;
      OFS_CTRL:     rdata_d[7:0] = {1'b0, hs_q, awake_indicator_n_q, 2'b00, ata_act_q, suspend_q, 1'b0};
      OFS_STATUS:   rdata_d[11:0] = {selfpwr_q, maxpwr_q, ata_float, media_present, vbus_q};
      OFS_SENSE:    rdata_d[15:0] = {sense_q.asc, sense_q.ascq};
      OFS_EP1:      rdata_d[16:0] = {ep1_valid, ep1_data};
      default:      err_d = 1'b1;
    endcase
  end

  // one wait state: answer in the cycle after access begins; pready drops the
  // cycle after it rises and rises again a cycle later, so a master holding its request
  // sees a pulse every second cycle and the side effects fire at each completing edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= rdata_d;
      pslverr <= psel & penable & ~pready & err_d;
    end
  end

endmodule
`default_nettype wire

// ### tb/pin_status_props.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module pin_status_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic vbus_present_input,
  input wire logic system_service_request,
  input wire logic awake_indicator_n_out,
  input wire logic awake_indicator_n_oe,
  input wire logic ata_pullup_control_out,
  input wire logic ata_pullup_control_oe,
  input wire logic ata_pins_oe,
  input wire logic ata_pins_active,
  input wire logic dplus_pullup,
  input wire logic high_current_grant_n,
  input wire logic ep1_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // access phase waiting for its answer
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_pulse;
    pready ##1 !pready;
  endsequence
  a_apb_wait_state: assert property (s_access |=> s_pulse)
    else $error("pready not one cycle after access");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_awake_drive_low: assert property (awake_indicator_n_oe |-> !awake_indicator_n_out)
    else $error("awake indicator driven high");
  a_pullup_floats: assert property (!ata_pins_oe |-> !ata_pullup_control_oe)
    else $error("pull-up control driven while ata floats");
  a_pullup_level: assert property (ata_pullup_control_oe |->
    ata_pullup_control_out == ata_pins_active)
    else $error("pull-up control level wrong");
  a_dplus_vbus: assert property ($rose(dplus_pullup) |->
    $past(vbus_present_input) || $past(vbus_present_input, 2))
    else $error("d+ pull-up on without vbus");
  a_ep1_cause: assert property ($rose(ep1_valid) |-> $past(system_service_request))
    else $error("ep1 valid without request");
  a_reset_pins: assert property (disable iff (1'b0) rst |=> high_current_grant_n
    && !ata_pins_oe && !awake_indicator_n_oe && !dplus_pullup)
    else $error("pins not at startup state in reset");
endmodule

bind pin_status pin_status_props u_props (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .vbus_present_input(vbus_present_input),
  .system_service_request(system_service_request),
  .awake_indicator_n_out(awake_indicator_n_out), .awake_indicator_n_oe(awake_indicator_n_oe),
  .ata_pullup_control_out(ata_pullup_control_out),
  .ata_pullup_control_oe(ata_pullup_control_oe), .ata_pins_oe(ata_pins_oe),
  .ata_pins_active(ata_pins_active), .dplus_pullup(dplus_pullup),
  .high_current_grant_n(high_current_grant_n), .ep1_valid(ep1_valid)
);
`default_nettype wire

// ### tb/gpio_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// board side of the gpio pins
// ------------------------------------------------------------
module gpio_pin_model #(
  parameter int W = 6
) (
  input  wire logic [W-1:0] drv_out,
  input  wire logic [W-1:0] drv_oe,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] pin_level
);
  // bridge wins where it drives, else the button level is seen
  assign pin_level = (drv_oe & drv_out) | (~drv_oe & ext_val);
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module testbench;
  import pin_status_pkg::*;
  localparam int POLL = 50;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, prdata_np, rd_np;
  logic pready, pslverr, err, awk_o, awk_oe, pu_o, pu_oe, ata_oe, ata_act, dplus, grant_n;
  logic media_in = 1'b0, vbus_in = 1'b1, pwr_sel = 1'b1, svc_req = 1'b0, media_p, ep1_v;
  logic [5:0] gpio_in, gpio_out, gpio_oe, ext_val = 6'h00;
  logic [15:0] ep1_d;
  logic [7:0] dir, val, m;
  int num_errors = 0, total_checks = 0, cyc = 0, absent = 0;
  // clock of 40 ns
  always #20 clk_sys = ~clk_sys;
  pin_status #(.POLL_CYC(POLL)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .media_present_input(media_in),
    .vbus_present_input(vbus_in), .power_source_select(pwr_sel),
    .system_service_request(svc_req), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .awake_indicator_n_out(awk_o), .awake_indicator_n_oe(awk_oe),
    .ata_pullup_control_out(pu_o), .ata_pullup_control_oe(pu_oe), .ata_pins_oe(ata_oe),
    .ata_pins_active(ata_act), .dplus_pullup(dplus), .high_current_grant_n(grant_n),
    .media_present(media_p), .ep1_valid(ep1_v), .ep1_data(ep1_d));
  gpio_pin_model #(.W(6)) u_pins (.drv_out(gpio_out), .drv_oe(gpio_oe), .ext_val(ext_val),
    .pin_level(gpio_in));
  // second unit without a power select pin, on the same bus
  pin_status #(.POLL_CYC(POLL), .HAS_PWRSEL(1'b0)) dut_np (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_np), .pready(), .pslverr(), .media_present_input(media_in),
    .vbus_present_input(vbus_in), .power_source_select(pwr_sel),
    .system_service_request(svc_req), .gpio_in(gpio_in), .gpio_out(), .gpio_oe(),
    .awake_indicator_n_out(), .awake_indicator_n_oe(), .ata_pullup_control_out(),
    .ata_pullup_control_oe(), .ata_pins_oe(), .ata_pins_active(), .dplus_pullup(),
    .high_current_grant_n(), .media_present(), .ep1_valid(), .ep1_data());
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    rd_np = prdata_np;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // host status query against the sense model
  task automatic query(input int mact);
    logic [15:0] e;
    e = (mact == 0) ? {ASC_NO_MEDIA, ASCQ_ZERO} : (absent != 0) ? {ASC_CHANGED, ASCQ_ZERO} : 16'h0;
    absent = (mact == 0);
    apb(1'b1, OFS_CTRL, 32'h10);
    apb(1'b0, OFS_SENSE, 32'h0);
    chk(rd, {16'h0, e});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'hb28d9c90));
    tick(20);
    chk({grant_n, ata_oe, awk_oe, dplus}, 4'b1000);
    rst <= 1'b0;
    tick(4);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h7d1);
    $display("test reset done");
    dir = 8'($urandom) & 8'h3f;
    val = 8'($urandom) & 8'h3f;
    apb(1'b1, OFS_GPIO_DIR, {24'h0, dir});
    apb(1'b1, OFS_GPIO_VAL, {24'h0, val});
    apb(1'b1, OFS_CTRL, 32'h41);
    tick(2);
    chk({gpio_oe, gpio_out}, {dir[5:0], val[5:0]});
    ext_val <= 6'($urandom);
    svc_req <= 1'b1;
    tick(1);
    svc_req <= 1'b0;
    tick(2);
    chk(ep1_d, {6'h0, 2'b11, 2'b00, ext_val & ~dir[5:0]});
    apb(1'b0, OFS_EP1, 32'h0);
    chk(rd, {15'h0, 1'b1, 6'h0, 2'b11, 2'b00, ext_val & ~dir[5:0]});
    apb(1'b0, OFS_EP1, 32'h0);
    chk(rd[16], 1'b0);
    $display("test gpio done");
    // removable-only system: one removable master, no fixed drive, search bit clear
    apb(1'b1, OFS_CFG, 32'h3);
    tick(3);
    chk(media_p, 1'b0);
    query(0);
    media_in <= 1'b1;
    tick(3);
    chk(media_p, 1'b1);
    query(1);
    query(1);
    apb(1'b1, OFS_CFG, 32'h1);
    tick(3);
    chk(media_p, 1'b0);
    $display("test media done");
    apb(1'b1, OFS_CFG, 32'h10);
    vbus_in <= 1'b0;
    tick(2 * POLL + 4);
    chk({ata_oe, pu_oe, dplus}, 3'b000);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[2:0], 3'b100);
    apb(1'b1, OFS_CFG, 32'h0);
    tick(3);
    chk(ata_oe, 1'b1);
    vbus_in <= 1'b1;
    tick(2 * POLL + 4);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    $display("test vbus done");
    apb(1'b1, OFS_CTRL, 32'h26);
    tick(3);
    chk({awk_oe, pu_o, grant_n, ata_act}, 4'b0111);
    apb(1'b1, OFS_CTRL, 32'h40);
    tick(3);
    chk({awk_oe, awk_o, pu_o, grant_n, ata_act}, 5'b10000);
    pwr_sel <= 1'b0;
    tick(3);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[11:3], {1'b0, MAXPWR_BUS});
    apb(1'b1, OFS_CTRL, 32'h48);
    tick(4);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[11:3], {1'b1, MAXPWR_SELF});
    // no select pin: configured value reported, self powered at 0x01 or less
    for (int i = 0; i < 2; i++) begin
      m = (i == 0) ? (8'($urandom) | 8'h02) : MAXPWR_SELF;
      apb(1'b1, OFS_MAXPWR, {24'h0, m});
      apb(1'b1, OFS_CTRL, 32'h48);
      tick(4);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd_np[11:3], {i == 1, m});
    end
    $display("test power done");
    apb(1'b1, 12'h020, 32'hffff_ffff);
    chk(err, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, OFS_CFG, 32'h13);
    rst <= 1'b1;
    tick(3);
    chk({grant_n, ata_oe}, 2'b10);
    rst <= 1'b0;
    tick(3);
    apb(1'b0, OFS_CFG, 32'h0);
    chk(rd, {24'h0, CFG_RST});
    $display("test errors and reset done");
    finish_test();
  end
endmodule
`default_nettype wire
